// ==== src/rup_pkg.sv ====
package rup_pkg;
  // Clock rates and the internal oscillator tick derived from the core clock
  localparam int unsigned CORE_CLK_HZ    = 50_000_000;
  localparam int unsigned OSC_CLK_HZ     = 10_000_000;
  localparam int unsigned OSC_DIV_CYCLES = CORE_CLK_HZ / OSC_CLK_HZ;
  localparam logic [3:0]  OSC_DIV_LAST   = 4'(OSC_DIV_CYCLES - 1);

  // Control and staging register layout
  localparam int unsigned CTRL_WIDTH     = 21;
  localparam int unsigned CTRL_ANF_BIT   = 0;
  localparam int unsigned CTRL_PAGE_LSB  = 1;
  localparam int unsigned CTRL_PAGE_MSB  = 7;
  localparam int unsigned CTRL_LOPG_MSB  = 3;
  localparam int unsigned CTRL_HIPG_LSB  = 4;
  localparam int unsigned CTRL_WDEN_BIT  = 8;
  localparam int unsigned CTRL_WDVAL_LSB = 9;
  localparam int unsigned CTRL_WDVAL_MSB = 20;

  // Control contents after reset or a reconfiguration event
  localparam logic [20:0] CTRL_ALL_ZERO  = 21'h000000;
  localparam logic [20:0] CTRL_LOCAL_APP = 21'h000003;

  // Cause flags
  localparam int unsigned CAUSE_WIDTH    = 5;
  localparam int unsigned CAUSE_CRC      = 0;
  localparam int unsigned CAUSE_EXT_ERR  = 1;
  localparam int unsigned CAUSE_CORE     = 2;
  localparam int unsigned CAUSE_RST_PIN  = 3;
  localparam int unsigned CAUSE_TIMEOUT  = 4;
  localparam logic [4:0]  CAUSE_RESET    = 5'h00;

  // Serial access shifter: staging or control on top, cause flags below
  localparam int unsigned SHIFT_WIDTH    = CTRL_WIDTH + CAUSE_WIDTH;
  localparam logic [25:0] SHIFT_RESET    = 26'h0000000;

  // Watchdog reload count: 12 set bits above 17 zero bits
  localparam int unsigned WD_WIDTH       = 29;
  localparam int unsigned WD_ZERO_BITS   = 17;
  localparam logic [16:0] WD_LOW_FILL    = 17'h00000;

  // Sequencer states
  typedef enum logic [1:0] {
    RUP_ST_INIT = 2'b00,
    RUP_ST_LOAD = 2'b01,
    RUP_ST_USER = 2'b10
  } rup_state_type;
endpackage

// ==== src/rup_core.sv ====
`timescale 1ns/1ps
module rup_core (
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        arst_n_in,
  // Straps
  input  wire logic        remote_mode_in,
  input  wire logic        active_serial_scheme_in,
  // Serial access port from the logic array
  input  wire logic        user_shift_clock_in,
  input  wire logic        shift_not_load_in,
  input  wire logic        capture_not_update_in,
  input  wire logic        serial_in_in,
  input  wire logic        logic_reconfig_request_n_in,
  input  wire logic        timer_restart_n_in,
  output logic             serial_out_out,
  // Configuration events
  input  wire logic        crc_error_in,
  input  wire logic        external_error_pin_n_in,
  input  wire logic        external_reset_pin_n_in,
  input  wire logic        config_done_in,
  // Configuration controls
  output logic             reconfig_start_out,
  output logic             user_mode_out,
  output logic [2:0]       page_select_out,
  output logic [6:0]       serial_start_address_out,
  output logic             app_not_factory_out,
  output logic [4:0]       reconfig_cause_out
);

  localparam int unsigned NSYNC = 9;

  logic [NSYNC-1:0]        sync1_reg;
  logic [NSYNC-1:0]        sync2_reg;
  logic [NSYNC-1:0]        sync3_reg;
  logic                    remote_reg;
  logic                    as_scheme_reg;
  logic [25:0]             serial_access_shifter_reg;
  logic [20:0]             pending_page_staging_reg;
  logic [20:0]             active_page_control_reg;
  logic [20:0]             active_page_control_next;
  logic [4:0]              reconfig_cause_reg;
  logic [4:0]              reconfig_cause_next;
  logic [4:0]              event_pend_reg;
  logic [3:0]              osc_div_reg;
  logic                    osc_tick;
  logic [28:0]             wd_count_reg;
  logic [28:0]             wd_reload;
  logic                    wd_run;
  logic                    wd_expired;
  rup_pkg::rup_state_type  state_reg;
  rup_pkg::rup_state_type  state_next;
  logic                    apply_event;
  logic                    start_pend_reg;

  // Synchronised inputs, named after the last stage
  logic                    clk_s;
  logic                    clk_rise;
  logic                    shift_s;
  logic                    capt_s;
  logic                    din_s;
  logic                    req_rise;
  logic                    restart_s;
  logic                    crc_rise;
  logic                    ext_err_fall;
  logic                    rst_pin_fall;
  logic                    done_rise;
  logic                    anf;
  logic                    write_ok;

  // Two-flop synchronisers plus one history stage for edge detection
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync1_reg <= {NSYNC{1'b1}};
      sync2_reg <= {NSYNC{1'b1}};
      sync3_reg <= {NSYNC{1'b1}};
    end else begin
      sync1_reg <= {user_shift_clock_in, shift_not_load_in, capture_not_update_in,
                    serial_in_in, logic_reconfig_request_n_in, timer_restart_n_in,
                    crc_error_in, external_reset_pin_n_in, config_done_in};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // Stages reset high, so a pin idling low only falls and gives no false rise
  assign clk_s        = sync2_reg[8];
  assign clk_rise     = clk_s & ~sync3_reg[8];
  assign shift_s      = sync2_reg[7];
  assign capt_s       = sync2_reg[6];
  assign din_s        = sync2_reg[5];
  assign req_rise     = sync2_reg[4] & ~sync3_reg[4];
  assign restart_s    = sync2_reg[3];
  assign crc_rise     = sync2_reg[2] & ~sync3_reg[2];
  assign rst_pin_fall = ~sync2_reg[1] & sync3_reg[1];
  assign done_rise    = sync2_reg[0] & ~sync3_reg[0];

  // Error pin has its own synchroniser, reset high like the others
  logic [2:0] err_sync_reg;
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      err_sync_reg <= 3'h7;
    end else begin
      err_sync_reg <= {err_sync_reg[1:0], external_error_pin_n_in};
    end
  end
  assign ext_err_fall = ~err_sync_reg[1] & err_sync_reg[2];

  // Flag low means a factory image, the only one allowed to write
  assign anf      = active_page_control_reg[rup_pkg::CTRL_ANF_BIT];
  assign write_ok = remote_reg & ~anf;

  // Serial access shifter on user shift clock edges
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      serial_access_shifter_reg <= rup_pkg::SHIFT_RESET;
    end else if (clk_rise) begin
      if (shift_s) begin
        serial_access_shifter_reg <= {din_s, serial_access_shifter_reg[25:1]};
      end else if (capt_s) begin
        // Factory reads see staging, applications see control
        serial_access_shifter_reg <= {(anf ? active_page_control_reg
                                           : pending_page_staging_reg),
                                      reconfig_cause_reg};
      end
    end
  end

  // Staging register written only from a factory image in remote mode
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pending_page_staging_reg <= rup_pkg::CTRL_ALL_ZERO;
    end else if (clk_rise && !shift_s && !capt_s && write_ok) begin
      pending_page_staging_reg <= serial_access_shifter_reg[25:5];
    end
  end

  // Serial output straight from the shifter's low flip-flop
  assign serial_out_out = serial_access_shifter_reg[0];

  // Internal oscillator tick derived from the core clock
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      osc_div_reg <= 4'h0;
    end else if (osc_div_reg == rup_pkg::OSC_DIV_LAST) begin
      osc_div_reg <= 4'h0;
    end else begin
      osc_div_reg <= osc_div_reg + 4'h1;
    end
  end
  assign osc_tick = (osc_div_reg == rup_pkg::OSC_DIV_LAST);

  // Watchdog: runs only for an enabled application image in user mode
  assign wd_reload  = {active_page_control_reg[rup_pkg::CTRL_WDVAL_MSB:rup_pkg::CTRL_WDVAL_LSB],
                       rup_pkg::WD_LOW_FILL};
  assign wd_run     = remote_reg & anf & active_page_control_reg[rup_pkg::CTRL_WDEN_BIT]
                      & (state_reg == rup_pkg::RUP_ST_USER);
  assign wd_expired = wd_run & (wd_count_reg == 29'h00000000);

  // Watchdog counter, held at reload while idle or restarted
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wd_count_reg <= 29'h00000000;
    end else if (!wd_run || !restart_s) begin
      wd_count_reg <= wd_reload;
    end else if (osc_tick && wd_count_reg != 29'h00000000) begin
      wd_count_reg <= wd_count_reg - 29'h00000001;
    end
  end

  // Pending events held until the next oscillator tick; a new event wins over the clear
  logic [4:0] event_now;
  assign event_now[rup_pkg::CAUSE_CRC]     = crc_rise & (state_reg == rup_pkg::RUP_ST_LOAD);
  assign event_now[rup_pkg::CAUSE_EXT_ERR] = ext_err_fall & (state_reg == rup_pkg::RUP_ST_LOAD);
  assign event_now[rup_pkg::CAUSE_CORE]    = req_rise & (state_reg == rup_pkg::RUP_ST_USER);
  assign event_now[rup_pkg::CAUSE_RST_PIN] = rst_pin_fall & (state_reg != rup_pkg::RUP_ST_INIT);
  // A standing timeout is not latched again while it is being applied
  assign event_now[rup_pkg::CAUSE_TIMEOUT] = wd_expired & ~event_pend_reg[rup_pkg::CAUSE_TIMEOUT];
  assign apply_event = osc_tick & (event_pend_reg != 5'h00);

  // Pending event flags
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      event_pend_reg <= 5'h00;
    end else if (apply_event) begin
      event_pend_reg <= event_now;
    end else begin
      event_pend_reg <= event_pend_reg | event_now;
    end
  end

  // Control and cause contents chosen by mode and highest-priority event
  always_comb begin
    active_page_control_next = active_page_control_reg;
    reconfig_cause_next      = reconfig_cause_reg;
    if (event_pend_reg[rup_pkg::CAUSE_RST_PIN]) begin
      reconfig_cause_next      = 5'h01 << rup_pkg::CAUSE_RST_PIN;
      active_page_control_next = remote_reg ? rup_pkg::CTRL_ALL_ZERO
                                            : rup_pkg::CTRL_LOCAL_APP;
    end else if (event_pend_reg[rup_pkg::CAUSE_EXT_ERR]) begin
      reconfig_cause_next      = 5'h01 << rup_pkg::CAUSE_EXT_ERR;
      active_page_control_next = rup_pkg::CTRL_ALL_ZERO;
    end else if (event_pend_reg[rup_pkg::CAUSE_CRC]) begin
      reconfig_cause_next      = 5'h01 << rup_pkg::CAUSE_CRC;
      active_page_control_next = rup_pkg::CTRL_ALL_ZERO;
    end else if (event_pend_reg[rup_pkg::CAUSE_TIMEOUT]) begin
      reconfig_cause_next      = 5'h01 << rup_pkg::CAUSE_TIMEOUT;
      active_page_control_next = rup_pkg::CTRL_ALL_ZERO;
    end else if (event_pend_reg[rup_pkg::CAUSE_CORE]) begin
      reconfig_cause_next      = 5'h01 << rup_pkg::CAUSE_CORE;
      // Remote copies staging with its flag untouched; local returns to page one
      active_page_control_next = remote_reg ? pending_page_staging_reg
                                            : rup_pkg::CTRL_LOCAL_APP;
    end
  end

  // Control register, initialised per strap after reset release
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      active_page_control_reg <= rup_pkg::CTRL_ALL_ZERO;
    end else if (state_reg == rup_pkg::RUP_ST_INIT) begin
      active_page_control_reg <= remote_mode_in ? rup_pkg::CTRL_ALL_ZERO
                                                : rup_pkg::CTRL_LOCAL_APP;
    end else if (apply_event) begin
      active_page_control_reg <= active_page_control_next;
    end
  end

  // Cause register, replaced whole by the winning event
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reconfig_cause_reg <= rup_pkg::CAUSE_RESET;
    end else if (apply_event) begin
      reconfig_cause_reg <= reconfig_cause_next;
    end
  end

  // Update mode strap, caught on the first edge after reset release
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      remote_reg <= 1'b0;
    end else if (state_reg == rup_pkg::RUP_ST_INIT) begin
      remote_reg <= remote_mode_in;
    end
  end

  // Scheme strap, caught on the same edge
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      as_scheme_reg <= 1'b0;
    end else if (state_reg == rup_pkg::RUP_ST_INIT) begin
      as_scheme_reg <= active_serial_scheme_in;
    end
  end

  // Sequencer: load an image, enter user mode, restart on any event
  always_comb begin
    case (state_reg)
      rup_pkg::RUP_ST_INIT: state_next = rup_pkg::RUP_ST_LOAD;
      rup_pkg::RUP_ST_LOAD: state_next = apply_event ? rup_pkg::RUP_ST_LOAD
          : (done_rise ? rup_pkg::RUP_ST_USER : rup_pkg::RUP_ST_LOAD);
      rup_pkg::RUP_ST_USER: state_next = apply_event ? rup_pkg::RUP_ST_LOAD
          : rup_pkg::RUP_ST_USER;
      default:              state_next = rup_pkg::RUP_ST_INIT;
    endcase
  end

  // Sequencer state register
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg <= rup_pkg::RUP_ST_INIT;
    end else begin
      state_reg <= state_next;
    end
  end

  // Start request on entry to loading, before the new control reaches the pins
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      start_pend_reg <= 1'b0;
    end else begin
      start_pend_reg <= (state_reg == rup_pkg::RUP_ST_INIT) || apply_event;
    end
  end

  // Start pulse delayed one cycle so it lines up with the page and cause outputs
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reconfig_start_out <= 1'b0;
    end else begin
      reconfig_start_out <= start_pend_reg;
    end
  end

  // Page select for the parallel and passive serial schemes
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      page_select_out <= 3'h0;
    end else begin
      page_select_out <= as_scheme_reg ? 3'h0
          : active_page_control_reg[rup_pkg::CTRL_LOPG_MSB:rup_pkg::CTRL_PAGE_LSB];
    end
  end

  // Start address bits for the active serial scheme
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      serial_start_address_out <= 7'h00;
    end else begin
      serial_start_address_out <= as_scheme_reg
          ? active_page_control_reg[rup_pkg::CTRL_PAGE_MSB:rup_pkg::CTRL_PAGE_LSB]
          : 7'h00;
    end
  end

  // Application flag output
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      app_not_factory_out <= 1'b0;
    end else begin
      app_not_factory_out <= anf;
    end
  end

  // Cause flags output
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reconfig_cause_out <= 5'h00;
    end else begin
      reconfig_cause_out <= reconfig_cause_reg;
    end
  end

  // User mode indication
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      user_mode_out <= 1'b0;
    end else begin
      user_mode_out <= (state_reg == rup_pkg::RUP_ST_USER);
    end
  end

endmodule

// ==== testbench/rup_core_props.sv ====
`timescale 1ns/1ps
module rup_core_props (
  // Clock, reset and straps
  input wire logic       core_clk_in,
  input wire logic       arst_n_in,
  input wire logic       remote_mode_in,
  input wire logic       active_serial_scheme_in,
  // Serial access and configuration outputs
  input wire logic       user_shift_clock_in,
  input wire logic       serial_out_out,
  input wire logic       reconfig_start_out,
  input wire logic       user_mode_out,
  input wire logic [2:0] page_select_out,
  input wire logic [6:0] serial_start_address_out,
  input wire logic       app_not_factory_out,
  input wire logic [4:0] reconfig_cause_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  logic [3:0] since_edge_reg;
  logic       sclk_seen_reg;

  // Core cycles since the shift clock pin last rose
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      since_edge_reg <= 4'hf;
      sclk_seen_reg  <= 1'b0;
    end else begin
      sclk_seen_reg <= user_shift_clock_in;
      if (user_shift_clock_in && !sclk_seen_reg) begin
        since_edge_reg <= 4'h0;
      end else if (since_edge_reg != 4'hf) begin
        since_edge_reg <= since_edge_reg + 4'h1;
      end
    end
  end

  // Sequencer outputs
  a_start_single: assert property (reconfig_start_out |=> !reconfig_start_out)
    else $error("reconfiguration start pulse too long");
  a_cause_onehot: assert property ($onehot0(reconfig_cause_out))
    else $error("more than one cause flag set");
  a_cause_hold: assert property (!reconfig_start_out |-> $stable(reconfig_cause_out))
    else $error("cause changed without a reconfiguration");
  a_control_hold: assert property (!reconfig_start_out |->
    $stable({page_select_out, serial_start_address_out, app_not_factory_out}))
    else $error("control changed without a reconfiguration");
  a_scheme_split: assert property (active_serial_scheme_in ?
    page_select_out == 3'h0 : serial_start_address_out == 7'h00)
    else $error("page field routed to the wrong scheme");
  a_remote_fault: assert property (remote_mode_in && reconfig_start_out &&
    !reconfig_cause_out[2] |-> page_select_out == 3'h0 && !app_not_factory_out &&
    serial_start_address_out == 7'h00)
    else $error("remote fault did not clear control");
  a_local_flag: assert property (!remote_mode_in && reconfig_start_out |->
    app_not_factory_out == (reconfig_cause_out[1:0] == 2'b00) &&
    page_select_out == {2'b00, app_not_factory_out})
    else $error("local page and flag disagree with cause");
  a_leave_user: assert property (reconfig_start_out |-> ##2 !user_mode_out)
    else $error("user mode kept after reconfiguration");
  a_serial_quiet: assert property ($changed(serial_out_out) |-> since_edge_reg <= 4'h6)
    else $error("serial output moved without a shift clock edge");

  // Main scenarios reached
  c_core_request: cover property (reconfig_start_out && reconfig_cause_out[2]);
  c_timeout: cover property (reconfig_start_out && reconfig_cause_out[4]);
  c_user_mode: cover property ($rose(user_mode_out));
endmodule

bind rup_core rup_core_props rup_core_props_inst (
  .core_clk_in, .arst_n_in, .remote_mode_in, .active_serial_scheme_in,
  .user_shift_clock_in, .serial_out_out, .reconfig_start_out, .user_mode_out,
  .page_select_out, .serial_start_address_out, .app_not_factory_out, .reconfig_cause_out
);

// ==== testbench/rup_user_logic.sv ====
`timescale 1ns/1ps
module rup_user_logic (
  // Core clock that paces every change
  input  wire logic core_clk_in,
  // Serial access lines toward the block
  input  wire logic serial_data_in,
  output logic      user_shift_clock_out,
  output logic      shift_not_load_out,
  output logic      capture_not_update_out,
  output logic      serial_data_out,
  // Reconfiguration request and guard timer restart
  output logic      reconfig_request_n_out,
  output logic      timer_restart_n_out
);
  // Idle levels: shift clock still, request released
  initial begin
    user_shift_clock_out   = 1'b0;
    shift_not_load_out     = 1'b0;
    capture_not_update_out = 1'b1;
    serial_data_out        = 1'b0;
    reconfig_request_n_out = 1'b1;
    timer_restart_n_out    = 1'b1;  // Never restarted, so an enabled timer runs out
  end

  // One 160 ns shift clock period, one core cycle of data setup first
  task automatic tick();
    @(negedge core_clk_in);
    user_shift_clock_out = 1'b1;
    repeat (4) @(negedge core_clk_in);
    user_shift_clock_out = 1'b0;
    repeat (3) @(negedge core_clk_in);
  endtask

  // Load the selected register into the shifter
  task automatic capture();
    shift_not_load_out     = 1'b0;
    capture_not_update_out = 1'b1;
    tick();
  endtask

  // Move the shifter into the staging register
  task automatic update();
    shift_not_load_out     = 1'b0;
    capture_not_update_out = 1'b0;
    tick();
    capture_not_update_out = 1'b1;
  endtask

  // Shift 26 bits, least significant first, reading what falls out
  task automatic xfer(input logic [25:0] din, output logic [25:0] dout);
    shift_not_load_out = 1'b1;
    for (int i = 0; i < 26; i++) begin
      serial_data_out = din[i];
      dout[i] = serial_data_in;
      tick();
    end
    serial_data_out = ~din[25];  // Line left showing the inverse of its last bit
  endtask

  // Low then high: the rising edge asks for reconfiguration
  task automatic request();
    reconfig_request_n_out = 1'b0;
    repeat (6) @(negedge core_clk_in);
    reconfig_request_n_out = 1'b1;
  endtask
endmodule

// ==== testbench/rup_core_tb_top.sv ====
`timescale 1ns/1ps
module rup_core_tb_top;
  // Block inputs, named as the ports they drive
  logic        core_clk_in             = 1'b0;
  logic        arst_n_in               = 1'b0;
  logic        remote_mode_in          = 1'b1;
  logic        active_serial_scheme_in = 1'b0;
  logic        crc_error_in            = 1'b0;
  logic        external_error_pin_n_in = 1'b1;
  logic        external_reset_pin_n_in = 1'b1;
  logic        config_done_in          = 1'b0;
  logic        user_shift_clock_in, shift_not_load_in, capture_not_update_in, serial_in_in;
  logic        logic_reconfig_request_n_in, timer_restart_n_in;
  // Block outputs and bench state
  logic        serial_out_out, reconfig_start_out, user_mode_out, app_not_factory_out;
  logic [2:0]  page_select_out;
  logic [6:0]  serial_start_address_out;
  logic [4:0]  reconfig_cause_out;
  logic [25:0] got;
  int          failures    = 0;
  int          check_count = 0;

  // Core clock, 50 MHz
  always #10 core_clk_in = ~core_clk_in;

  rup_core rup_core_inst (
    .core_clk_in, .arst_n_in, .remote_mode_in, .active_serial_scheme_in,
    .user_shift_clock_in, .shift_not_load_in, .capture_not_update_in, .serial_in_in,
    .logic_reconfig_request_n_in, .timer_restart_n_in, .serial_out_out,
    .crc_error_in, .external_error_pin_n_in, .external_reset_pin_n_in, .config_done_in,
    .reconfig_start_out, .user_mode_out, .page_select_out, .serial_start_address_out,
    .app_not_factory_out, .reconfig_cause_out
  );
  rup_user_logic rup_user_logic_inst (
    .core_clk_in, .serial_data_in(serial_out_out),
    .user_shift_clock_out(user_shift_clock_in), .shift_not_load_out(shift_not_load_in),
    .capture_not_update_out(capture_not_update_in), .serial_data_out(serial_in_in),
    .reconfig_request_n_out(logic_reconfig_request_n_in),
    .timer_restart_n_out(timer_restart_n_in)
  );

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask
  // Start address, page, flag and cause in one word
  function automatic logic [15:0] outs();
    return {serial_start_address_out, page_select_out, app_not_factory_out, reconfig_cause_out};
  endfunction
  // Reset with new straps, caught as reset lets go
  task automatic do_reset(input logic remote, input logic as_scheme);
    arst_n_in = 1'b0;
    remote_mode_in = remote;
    active_serial_scheme_in = as_scheme;
    cyc(16);
    arst_n_in = 1'b1;
    cyc(12);
  endtask
  task automatic finish_load();
    config_done_in = 1'b1;
    cyc(12);
    config_done_in = 1'b0;
  endtask
  // Read the selected register, write a staging value, then update
  task automatic stage(input logic [20:0] v);
    rup_user_logic_inst.capture();
    rup_user_logic_inst.xfer({v, 5'h00}, got);
    rup_user_logic_inst.update();
  endtask
  task automatic peek();
    rup_user_logic_inst.capture();
    rup_user_logic_inst.xfer(26'h0000000, got);
  endtask
  task automatic request();
    rup_user_logic_inst.request();
    cyc(15);
  endtask
  // Pulse one event pin: 0 checksum error, 1 external error, 2 reset pin
  task automatic event_pin(input int k);
    crc_error_in = (k == 0);
    external_error_pin_n_in = (k != 1);
    external_reset_pin_n_in = (k != 2);
    cyc(4);
    crc_error_in = 1'b0;
    external_error_pin_n_in = 1'b1;
    external_reset_pin_n_in = 1'b1;
    cyc(15);
  endtask

  // Remote mode, parallel scheme: factory writes staging, application cannot
  task automatic test_remote();
    do_reset(1'b1, 1'b0);
    chk(outs(), 16'h0000);
    finish_load();
    chk(user_mode_out, 1'b1);
    stage(21'h14b85b);
    chk(got, 26'h0000000);
    peek();
    chk(got, {21'h14b85b, 5'h00});
    request();
    chk({user_mode_out, outs()}, {1'b0, 16'h0164});
    finish_load();
    stage(21'h000007);
    chk(got, {21'h14b85b, 5'h04});
    request();
    chk(outs(), 16'h0164);
  endtask
  // Active serial scheme: start address, timer idle for factory, timeout
  task automatic test_timeout();
    do_reset(1'b1, 1'b1);
    finish_load();
    stage(21'h0001b4);
    request();
    chk(outs(), 16'hb404);
    finish_load();
    cyc(40);
    chk(outs(), 16'hb404);
    stage(21'h0001b5);
    request();
    chk(outs(), 16'hb424);
    finish_load();
    cyc(20);
    chk(outs(), 16'h0010);
  endtask
  // Local mode: fixed application page, fallback on load errors
  task automatic test_local();
    do_reset(1'b0, 1'b0);
    chk(outs(), 16'h0060);
    stage(21'h000000);
    chk(got, {21'h000003, 5'h00});
    peek();
    chk(got, {21'h000003, 5'h00});
    for (int k = 0; k < 3; k++) begin
      event_pin(k);
      chk(outs(), (k == 2) ? 16'h0068 : 16'(k + 1));
    end
    finish_load();
    request();
    chk(outs(), 16'h0064);
  endtask

  // Main sequence
  initial begin
    test_remote();
    test_timeout();
    test_local();
    give_verdict();
  end
  // Hang guard, well beyond the few tens of microseconds the tests need
  initial begin
    #2000000;
    failures++;
    give_verdict();
  end
endmodule
